// ===== amcd_clkdiv.sv
`timescale 1ns/10ps
module amcd_clkdiv (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Divider code
  input wire logic [7:0] div_code,
  // Divided clock
  output logic converter_clock
);
  import amcd_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic clk_out;
  } amcd_div_st_t;

  amcd_div_st_t st_q;
  amcd_div_st_t st_d;
  logic [7:0] divisor;

  always_comb begin
    st_d = st_q;
    // Codes below the minimum all divide by two
    divisor = (div_code < AMCD_DIV_MIN) ? AMCD_DIV_MIN : div_code;
    if (st_q.cnt >= divisor - 8'h01) begin
      st_d.cnt = 8'h00;
    end else begin
      st_d.cnt = st_q.cnt + 8'h01;
    end
    st_d.clk_out = (st_d.cnt < (divisor >> 1));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign converter_clock = st_q.clk_out;

endmodule // amcd_clkdiv

// ===== amcd_jtag_host.sv
`timescale 1ns/10ps
module amcd_jtag_host (
  // Link pins
  output logic jtag_tck,
  output logic jtag_tms,
  output logic jtag_tdi,
  input wire logic jtag_tdo,
  input wire logic jtag_tdo_oe
);
  logic alt_q = 1'b0;
  wire tdo_w;
  // Released line shows a changing level
  always @(posedge jtag_tck) alt_q <= ~alt_q;
  assign tdo_w = jtag_tdo_oe ? jtag_tdo : alt_q;
  initial begin
    jtag_tck = 1'b0;
    jtag_tms = 1'b1;
    jtag_tdi = 1'b0;
  end
  // One 800 ns period; clock stands low between frames
  task automatic step(input logic m, input logic d, output logic q);
    jtag_tms <= m;
    jtag_tdi <= d;
    #400 jtag_tck <= 1'b1;
    q = tdo_w;
    #400 jtag_tck <= 1'b0;
  endtask
  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // Instruction scan must come before data scans
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    repeat (4) step(1'b0, 1'b0, q);
  endtask
endmodule // amcd_jtag_host

// ===== amcd_monitor_ctrl.sv
`timescale 1ns/10ps
module amcd_monitor_ctrl #(
  parameter int unsigned IR_LEN = 6,
  parameter amcd_pkg::amcd_access_t ACCESS = amcd_pkg::AMCD_ACC_FULL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Interconnect register port
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_ready,
  // I2C side request port
  input wire logic i2c_req,
  input wire logic i2c_we,
  input wire logic [9:0] i2c_addr,
  input wire logic [15:0] i2c_wdata,
  output logic [15:0] i2c_rdata,
  output logic i2c_ack,
  // Boundary-scan pins
  input wire logic jtag_tck,
  input wire logic jtag_tms,
  input wire logic jtag_tdi,
  output logic jtag_tdo,
  output logic jtag_tdo_oe,
  // Handshake flags
  output logic tap_access_busy,
  output logic tap_write_flag,
  output logic tap_port_lockout,
  // Decoded configuration
  output amcd_pkg::amcd_chan_t chan_kind,
  output logic [5:0] chan_index,
  output logic calibrate_start,
  output logic [8:0] avg_samples,
  output amcd_pkg::amcd_seq_t seq_mode,
  output logic converter_offset_correct_en,
  output logic supply_offset_correct_en,
  output logic supply_offset_gain_correct_en,
  output logic converter_clock
);
  import amcd_pkg::*;

  typedef struct packed {
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic lock;
    logic modified;
    logic tap_pend;
    logic [31:0] tap_cmd;
    logic [15:0] tap_result;
    logic bus_pend;
    logic bus_we;
    logic [9:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] rdata;
    logic ready;
    logic [15:0] i2c_rdata;
    logic i2c_ack;
    logic [2:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    amcd_chan_t chan;
    logic calib;
    logic [8:0] avg;
    amcd_seq_t seq;
  } amcd_state_t;

  amcd_state_t s_q;
  amcd_state_t s_d;
  logic tck_rise;
  logic tck_fall;
  logic upd_valid;
  logic [31:0] upd_word;
  logic [3:0] tap_op;
  logic [9:0] tap_addr;
  logic [15:0] tap_data;
  logic bus_go;
  logic bus_go_we;
  logic [9:0] bus_go_addr;
  logic [15:0] bus_go_wdata;
  logic tap_done;

  function automatic logic [15:0] amcd_read(amcd_state_t s, logic [9:0] a);
    case (a)
      AMCD_ADDR_LOCK: amcd_read = {15'h0000, s.lock};
      AMCD_ADDR_STATUS: amcd_read = {13'h0000, s.tap_pend, s.modified, s.lock};
      AMCD_ADDR_CFG0: amcd_read = s.cfg0;
      AMCD_ADDR_CFG1: amcd_read = s.cfg1;
      AMCD_ADDR_CFG2: amcd_read = s.cfg2;
      default: amcd_read = 16'h0000;
    endcase
  endfunction

  function automatic amcd_state_t amcd_write(amcd_state_t s, logic [9:0] a, logic [15:0] v);
    amcd_state_t t;
    t = s;
    case (a)
      AMCD_ADDR_LOCK: t.lock = (v == AMCD_LOCK_KEY);
      AMCD_ADDR_CFG0: begin
        t.cfg0 = v;
        t.calib = (v[AMCD_CH_LSB +: 6] == 6'h08);
      end
      AMCD_ADDR_CFG1: t.cfg1 = v;
      AMCD_ADDR_CFG2: t.cfg2 = v;
      default: ;
    endcase
    amcd_write = t;
  endfunction

  function automatic amcd_chan_t amcd_chan_decode(logic [5:0] c);
    case (c)
      6'h00: amcd_chan_decode = AMCD_CH_TEMP;
      6'h01, 6'h02, 6'h06: amcd_chan_decode = AMCD_CH_SUPPLY;
      6'h03: amcd_chan_decode = AMCD_CH_DEDICATED;
      6'h04, 6'h05: amcd_chan_decode = AMCD_CH_REF;
      6'h08: amcd_chan_decode = AMCD_CH_CALIB;
      6'h07, 6'h09, 6'h0a, 6'h0b, 6'h0c: amcd_chan_decode = AMCD_CH_INVALID;
      default: amcd_chan_decode = AMCD_CH_OTHER;
    endcase
  endfunction

  function automatic amcd_seq_t amcd_seq_decode(logic [3:0] m);
    case (m)
      4'h0, 4'hc, 4'hd, 4'he, 4'hf: amcd_seq_decode = AMCD_SEQ_DEFAULT;
      4'h1: amcd_seq_decode = AMCD_SEQ_SINGLE_PASS;
      4'h2: amcd_seq_decode = AMCD_SEQ_CONTINUOUS;
      4'h3: amcd_seq_decode = AMCD_SEQ_SINGLE_CHAN;
      default: amcd_seq_decode = AMCD_SEQ_UNDEFINED;
    endcase
  endfunction

  function automatic logic [8:0] amcd_avg_decode(logic [1:0] g);
    case (g)
      2'h1: amcd_avg_decode = 9'h010;
      2'h2: amcd_avg_decode = 9'h040;
      2'h3: amcd_avg_decode = 9'h100;
      default: amcd_avg_decode = 9'h000;
    endcase
  endfunction

  // Edge detection reads only the second and third sampling stages
  assign tck_rise = s_q.tck_sync[1] && !s_q.tck_sync[2];
  assign tck_fall = !s_q.tck_sync[1] && s_q.tck_sync[2];

  // Fixed boundary-scan hookup; no user-side wiring is involved
  amcd_tap #(
    .IR_LEN(IR_LEN),
    .ACCESS(ACCESS)
  ) u_tap (
    .clk(clk),
    .sys_rst(sys_rst),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .tms(s_q.tms_sync[1]),
    .tdi(s_q.tdi_sync[1]),
    .tdo(jtag_tdo),
    .tdo_oe(jtag_tdo_oe),
    .capture_word({16'h0000, s_q.tap_result}),
    .upd_valid(upd_valid),
    .upd_word(upd_word)
  );

  amcd_clkdiv u_clkdiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .div_code(s_q.cfg2[AMCD_CD_LSB +: 8]),
    .converter_clock(converter_clock)
  );

  assign tap_op = s_q.tap_cmd[AMCD_DR_CMD_LSB +: 4];
  assign tap_addr = s_q.tap_cmd[AMCD_DR_ADDR_LSB +: 10];
  assign tap_data = s_q.tap_cmd[15:0];

  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b0;
    s_d.i2c_ack = 1'b0;
    s_d.calib = 1'b0;
    s_d.tck_sync = {s_q.tck_sync[1:0], jtag_tck};
    s_d.tms_sync = {s_q.tms_sync[0], jtag_tms};
    s_d.tdi_sync = {s_q.tdi_sync[0], jtag_tdi};
    bus_go = 1'b0;
    bus_go_we = 1'b0;
    bus_go_addr = '0;
    bus_go_wdata = '0;
    tap_done = 1'b0;
    // A fresh strobe is served at once unless the port is locked (then it is dropped) or a TAP transaction is waiting
    if ((reg_wr || reg_rd) && !s_q.lock) begin
      if (s_q.tap_pend) begin
        s_d.bus_pend = 1'b1;
        s_d.bus_we = reg_wr;
        s_d.bus_addr = reg_addr;
        s_d.bus_wdata = reg_wdata;
      end else begin
        bus_go = 1'b1;
        bus_go_we = reg_wr;
        bus_go_addr = reg_addr;
        bus_go_wdata = reg_wdata;
      end
    end else if (s_q.bus_pend && !s_q.tap_pend) begin
      bus_go = 1'b1;
      bus_go_we = s_q.bus_we;
      bus_go_addr = s_q.bus_addr;
      bus_go_wdata = s_q.bus_wdata;
      s_d.bus_pend = 1'b0;
    end
    if (bus_go) begin
      s_d.ready = 1'b1;
      s_d.modified = 1'b0;
      if (bus_go_we) begin
        s_d = amcd_write(s_d, bus_go_addr, bus_go_wdata);
      end else begin
        s_d.rdata = amcd_read(s_q, bus_go_addr);
      end
    end else if (s_q.tap_pend) begin
      // Served in the first cycle it is pending, since interconnect accesses wait behind it, well inside the bound
      tap_done = 1'b1;
      if (tap_op == AMCD_CMD_READ && (ACCESS == AMCD_ACC_FULL || tap_addr < AMCD_ADDR_CFG0)) begin
        s_d.tap_result = amcd_read(s_q, tap_addr);
      end else if (tap_op == AMCD_CMD_WRITE && ACCESS == AMCD_ACC_FULL) begin
        s_d = amcd_write(s_d, tap_addr, tap_data);
        s_d.tap_result = tap_data;
        s_d.modified = 1'b1;
      end
    end else if (i2c_req && !s_q.i2c_ack) begin
      s_d.i2c_ack = 1'b1;
      if (i2c_we) begin
        s_d = amcd_write(s_d, i2c_addr, i2c_wdata);
      end else begin
        s_d.i2c_rdata = amcd_read(s_q, i2c_addr);
      end
    end
    if (tap_done) begin
      s_d.tap_pend = 1'b0;
    end
    // A new update arriving with one outstanding is dropped
    if (upd_valid && !s_q.tap_pend) begin
      s_d.tap_pend = 1'b1;
      s_d.tap_cmd = upd_word;
    end
    s_d.chan = amcd_chan_decode(s_d.cfg0[AMCD_CH_LSB +: 6]);
    s_d.avg = amcd_avg_decode(s_d.cfg0[AMCD_AVG_LSB +: 2]);
    s_d.seq = amcd_seq_decode(s_d.cfg1[AMCD_SEQ_LSB +: 4]);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '{cfg0: AMCD_CFG0_RST, cfg1: AMCD_CFG1_RST, cfg2: AMCD_CFG2_RST,
               chan: AMCD_CH_TEMP, seq: AMCD_SEQ_DEFAULT, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign reg_ready = s_q.ready;
  assign i2c_rdata = s_q.i2c_rdata;
  assign i2c_ack = s_q.i2c_ack;
  assign tap_access_busy = s_q.tap_pend;
  assign tap_write_flag = s_q.modified;
  assign tap_port_lockout = s_q.lock;
  assign chan_kind = s_q.chan;
  assign chan_index = s_q.cfg0[AMCD_CH_LSB +: 6];
  assign calibrate_start = s_q.calib;
  assign avg_samples = s_q.avg;
  assign seq_mode = s_q.seq;
  assign converter_offset_correct_en = s_q.cfg1[AMCD_CAL_CONV_BIT];
  assign supply_offset_correct_en = s_q.cfg1[AMCD_CAL_SOFF_BIT];
  assign supply_offset_gain_correct_en = s_q.cfg1[AMCD_CAL_SGAIN_BIT];

endmodule // amcd_monitor_ctrl

// ===== amcd_monitor_ctrl_monitor.sv
`timescale 1ns/10ps
module amcd_monitor_ctrl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_ready,
  // Flags and decode
  input wire logic tap_access_busy,
  input wire logic tap_write_flag,
  input wire logic tap_port_lockout,
  input wire amcd_pkg::amcd_chan_t chan_kind,
  input wire logic [5:0] chan_index,
  input wire logic calibrate_start
);
  import amcd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire strobe = reg_wr || reg_rd;
  strobe_ready_a: assert property (
    strobe && !tap_port_lockout && !tap_access_busy |=> reg_ready)
    else $error("access not answered");
  locked_drop_a: assert property (strobe && tap_port_lockout |=> !reg_ready)
    else $error("locked access answered");
  ready_busy_a: assert property (reg_ready |-> !$past(tap_access_busy))
    else $error("ready while busy");
  busy_bound_a: assert property (
    $rose(tap_access_busy) |-> ##[1:18] !tap_access_busy)
    else $error("busy too long");
  flag_clear_a: assert property (reg_ready |-> !tap_write_flag)
    else $error("flag not cleared");
  flag_set_a: assert property ($rose(tap_write_flag) |-> $past(tap_access_busy))
    else $error("flag set outside transfer");
  cal_pulse_a: assert property (calibrate_start |-> ##[0:1] chan_index == 6'h08)
    else $error("stray calibrate pulse");
  chan_supply_a: assert property (
    $stable(chan_index) && chan_index inside {6'h01, 6'h02, 6'h06} |-> chan_kind == AMCD_CH_SUPPLY)
    else $error("supply decode");
  chan_bad_a: assert property (
    $stable(chan_index) && chan_index inside {6'h07, [6'h09:6'h0c]}
    |-> chan_kind == AMCD_CH_INVALID)
    else $error("invalid decode");
  cover property ($rose(tap_access_busy));
  cover property ($rose(tap_write_flag));
  cover property (strobe && tap_port_lockout);
  cover property (strobe && tap_access_busy);
endmodule // amcd_monitor_ctrl_monitor
bind amcd_monitor_ctrl amcd_monitor_ctrl_monitor u_mon (.clk, .sys_rst, .reg_wr, .reg_rd,
  .reg_ready, .tap_access_busy, .tap_write_flag, .tap_port_lockout, .chan_kind, .chan_index,
  .calibrate_start);

// ===== amcd_monitor_ctrl_test.sv
`timescale 1ns/10ps
module amcd_monitor_ctrl_test;
  import amcd_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, reg_ready, i2c_req, i2c_we, i2c_ack, calibrate_start;
  logic [9:0] reg_addr, i2c_addr;
  logic [15:0] reg_wdata, i2c_wdata, reg_rdata, i2c_rdata, q;
  logic jtag_tck, jtag_tms, jtag_tdi, jtag_tdo, jtag_tdo_oe, converter_clock;
  logic tap_access_busy, tap_write_flag, tap_port_lockout;
  logic converter_offset_correct_en, supply_offset_correct_en, supply_offset_gain_correct_en;
  logic [5:0] chan_index;
  logic [8:0] avg_samples;
  logic [31:0] cap;
  amcd_chan_t chan_kind;
  amcd_seq_t seq_mode;
  int miscompares = 0;
  int samples_checked = 0;
  int cal_n = 0;
  amcd_chan_t ch_exp [13] = '{AMCD_CH_TEMP, AMCD_CH_SUPPLY, AMCD_CH_SUPPLY, AMCD_CH_DEDICATED,
    AMCD_CH_REF, AMCD_CH_REF, AMCD_CH_SUPPLY, AMCD_CH_INVALID, AMCD_CH_CALIB, AMCD_CH_INVALID,
    AMCD_CH_INVALID, AMCD_CH_INVALID, AMCD_CH_INVALID};
  amcd_seq_t seq_exp [7] = '{AMCD_SEQ_DEFAULT, AMCD_SEQ_SINGLE_PASS, AMCD_SEQ_CONTINUOUS,
    AMCD_SEQ_SINGLE_CHAN, AMCD_SEQ_DEFAULT, AMCD_SEQ_DEFAULT, AMCD_SEQ_UNDEFINED};
  logic [3:0] seq_in [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hc, 4'hf, 4'h4};
  logic [8:0] avg_exp [4] = '{9'h000, 9'h010, 9'h040, 9'h100};
  logic [2:0] cal_exp [4] = '{3'h4, 3'h0, 3'h2, 3'h1};
  int dv [6] = '{0, 1, 2, 3, 5, 255};
  int dx [6] = '{2, 2, 2, 3, 5, 255};

  amcd_monitor_ctrl DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_ready, .i2c_req, .i2c_we, .i2c_addr, .i2c_wdata, .i2c_rdata, .i2c_ack, .jtag_tck,
    .jtag_tms, .jtag_tdi, .jtag_tdo, .jtag_tdo_oe, .tap_access_busy, .tap_write_flag,
    .tap_port_lockout, .chan_kind, .chan_index, .calibrate_start, .avg_samples, .seq_mode,
    .converter_offset_correct_en, .supply_offset_correct_en, .supply_offset_gain_correct_en,
    .converter_clock);
  amcd_jtag_host host (.jtag_tck, .jtag_tms, .jtag_tdi, .jtag_tdo, .jtag_tdo_oe);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (calibrate_start === 1'b1) cal_n++;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic lim(input logic ok);
    if (!ok) begin
      chk(32'h0, 32'h1);
      complete_run();
    end
  endtask
  task automatic reg_acc(input logic w, input logic [9:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reg_ready !== 1'b1 && n < 20);
    q = reg_rdata;
    lim(reg_ready === 1'b1);
  endtask
  task automatic i2c_acc(input logic w, input logic [9:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    i2c_req <= 1'b1;
    i2c_we <= w;
    i2c_addr <= a;
    i2c_wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (i2c_ack !== 1'b1 && n < 20);
    i2c_req <= 1'b0;
    q = i2c_rdata;
    lim(i2c_ack === 1'b1);
  endtask
  task automatic rise(output int n);
    logic p;
    n = 0;
    do begin
      p = converter_clock;
      @(posedge clk);
      n++;
    end while (!(p === 1'b0 && converter_clock === 1'b1) && n < 600);
    lim(n < 600);
  endtask

  task automatic sc_decode();
    for (int i = 0; i < 13; i++) begin
      reg_acc(1'b1, AMCD_ADDR_CFG0, 16'(i % 4) << 12 | 16'(i));
      chk(chan_kind, ch_exp[i]);
      chk(chan_index, i);
      chk(avg_samples, avg_exp[i % 4]);
      reg_acc(1'b0, AMCD_ADDR_CFG0, 16'h0);
      chk(q, 16'(i % 4) << 12 | 16'(i));
    end
    chk(cal_n, 1);
    for (int i = 0; i < 7; i++) begin
      reg_acc(1'b1, AMCD_ADDR_CFG1, {seq_in[i], 12'h000});
      chk(seq_mode, seq_exp[i]);
    end
    for (int k = 0; k < 4; k++) begin
      reg_acc(1'b1, AMCD_ADDR_CFG1, 16'h0010 << k);
      chk({converter_offset_correct_en, supply_offset_correct_en,
        supply_offset_gain_correct_en}, cal_exp[k]);
    end
  endtask
  task automatic sc_div();
    int n;
    for (int i = 0; i < 6; i++) begin
      reg_acc(1'b1, AMCD_ADDR_CFG2, 16'(dv[i]) << 8);
      rise(n);
      rise(n);
      rise(n);
      chk(n, dx[i]);
    end
  endtask
  task automatic sc_lock();
    int n;
    reg_acc(1'b1, AMCD_ADDR_LOCK, AMCD_LOCK_KEY);
    chk(tap_port_lockout, 1'b1);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= AMCD_ADDR_CFG0;
    @(posedge clk);
    reg_rd <= 1'b0;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      if (reg_ready === 1'b1) n++;
    end
    chk(n, 0);
    i2c_acc(1'b1, AMCD_ADDR_LOCK, 16'h0);
    chk(tap_port_lockout, 1'b0);
    i2c_acc(1'b0, AMCD_ADDR_CFG2, 16'h0);
    chk(q, 16'hff00);
  endtask
  task automatic sc_tap();
    int n;
    time t0;
    host.reset_tap();
    host.scan(1'b1, 6, 32'(AMCD_IR_MON6), cap);
    host.scan(1'b0, 32, {2'b00, AMCD_CMD_WRITE, AMCD_ADDR_CFG0, 16'h3003}, cap);
    chk(cap, 32'h0);
    chk(tap_write_flag, 1'b1);
    chk(tap_access_busy, 1'b0);
    chk(chan_kind, AMCD_CH_DEDICATED);
    reg_acc(1'b0, AMCD_ADDR_CFG0, 16'h0);
    chk(q, 16'h3003);
    chk(tap_write_flag, 1'b0);
    reg_acc(1'b1, AMCD_ADDR_CFG2, 16'h0700);
    fork
      host.scan(1'b0, 32, {2'b00, AMCD_CMD_READ, AMCD_ADDR_CFG2, 16'h0}, cap);
      begin
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (jtag_tdo_oe !== 1'b1 && n < 1000);
        lim(n < 1000);
        // End of shift; the strobe then lands while the update is pending
        do begin
          @(posedge clk);
          n++;
        end while (jtag_tdo_oe !== 1'b0 && n < 1000);
        lim(n < 1000);
        repeat (7) @(posedge clk);
        t0 = $time;
        reg_acc(1'b0, AMCD_ADDR_CFG0, 16'h0);
        chk(32'(($time - t0) / 100), 4);
      end
    join
    chk(cap, 32'h0000_3003);
    chk(q, 16'h3003);
    host.scan(1'b0, 32, 32'h0, cap);
    chk(cap, 32'h0000_0700);
    chk(tap_write_flag, 1'b0);
  endtask

  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, i2c_req, i2c_we} = 4'h0;
    {reg_addr, i2c_addr, reg_wdata, i2c_wdata} = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(seq_mode, AMCD_SEQ_DEFAULT);
    reg_acc(1'b0, 10'h3ff, 16'h0);
    chk(q, 16'h0);
    sc_decode();
    sc_div();
    sc_lock();
    sc_tap();
    complete_run();
  end
  initial begin
    #8000000;
    lim(1'b0);
  end
endmodule // amcd_monitor_ctrl_test

// ===== amcd_pkg.sv
package amcd_pkg;

  // Widths
  localparam int unsigned AMCD_ADDR_W = 10;
  localparam int unsigned AMCD_DATA_W = 16;
  localparam int unsigned AMCD_DR_W = 32;
  localparam int unsigned AMCD_IR_MAX = 12;

  // Register offsets
  localparam logic [9:0] AMCD_ADDR_LOCK = 10'h000;
  localparam logic [9:0] AMCD_ADDR_STATUS = 10'h03f;
  localparam logic [9:0] AMCD_ADDR_CFG0 = 10'h040;
  localparam logic [9:0] AMCD_ADDR_CFG1 = 10'h041;
  localparam logic [9:0] AMCD_ADDR_CFG2 = 10'h042;

  // Reset values and lock key
  localparam logic [15:0] AMCD_CFG0_RST = 16'h0000;
  localparam logic [15:0] AMCD_CFG1_RST = 16'h0000;
  localparam logic [15:0] AMCD_CFG2_RST = 16'h0000;
  localparam logic [15:0] AMCD_LOCK_KEY = 16'h0001;

  // Field positions
  localparam int unsigned AMCD_CH_LSB = 0;
  localparam int unsigned AMCD_AVG_LSB = 12;
  localparam int unsigned AMCD_CAL_CONV_BIT = 4;
  localparam int unsigned AMCD_CAL_RSVD_BIT = 5;
  localparam int unsigned AMCD_CAL_SOFF_BIT = 6;
  localparam int unsigned AMCD_CAL_SGAIN_BIT = 7;
  localparam int unsigned AMCD_SEQ_LSB = 12;
  localparam int unsigned AMCD_CD_LSB = 8;
  localparam int unsigned AMCD_STAT_LOCK_BIT = 0;
  localparam int unsigned AMCD_STAT_MOD_BIT = 1;
  localparam int unsigned AMCD_STAT_BUSY_BIT = 2;

  // Monitor shift-register command word
  localparam int unsigned AMCD_DR_ADDR_LSB = 16;
  localparam int unsigned AMCD_DR_CMD_LSB = 26;
  localparam logic [3:0] AMCD_CMD_NOP = 4'h0;
  localparam logic [3:0] AMCD_CMD_READ = 4'h1;
  localparam logic [3:0] AMCD_CMD_WRITE = 4'h2;

  // Monitor access instruction codes
  localparam logic [11:0] AMCD_IR_MON6 = 12'h037;
  localparam logic [11:0] AMCD_IR_MON12 = 12'hff7;
  localparam logic [11:0] AMCD_IR_MASK6 = 12'h03f;
  localparam logic [11:0] AMCD_IR_MASK12 = 12'hfff;
  localparam logic [11:0] AMCD_IR_CAPTURE = 12'h001;

  // Converter clock division
  localparam logic [7:0] AMCD_DIV_MIN = 8'h02;

  // Tap transfer bound, port clock cycles
  localparam int unsigned AMCD_TAP_XFER_MAX_CYC = 18;

  typedef enum logic [1:0] {
    AMCD_ACC_FULL = 2'h0,
    AMCD_ACC_STATUS_ONLY = 2'h1,
    AMCD_ACC_DISABLED = 2'h3
  } amcd_access_t;

  typedef enum logic [2:0] {
    AMCD_CH_TEMP = 3'h0,
    AMCD_CH_SUPPLY = 3'h1,
    AMCD_CH_DEDICATED = 3'h2,
    AMCD_CH_REF = 3'h3,
    AMCD_CH_CALIB = 3'h4,
    AMCD_CH_INVALID = 3'h5,
    AMCD_CH_OTHER = 3'h6
  } amcd_chan_t;

  typedef enum logic [2:0] {
    AMCD_SEQ_DEFAULT = 3'h0,
    AMCD_SEQ_SINGLE_PASS = 3'h1,
    AMCD_SEQ_CONTINUOUS = 3'h2,
    AMCD_SEQ_SINGLE_CHAN = 3'h3,
    AMCD_SEQ_UNDEFINED = 3'h4
  } amcd_seq_t;

  typedef enum logic [3:0] {
    AMCD_TS_RESET = 4'h0,
    AMCD_TS_IDLE = 4'h1,
    AMCD_TS_SEL_DR = 4'h3,
    AMCD_TS_CAP_DR = 4'h2,
    AMCD_TS_SH_DR = 4'h6,
    AMCD_TS_EX1_DR = 4'h7,
    AMCD_TS_PAU_DR = 4'h5,
    AMCD_TS_EX2_DR = 4'h4,
    AMCD_TS_UPD_DR = 4'hc,
    AMCD_TS_SEL_IR = 4'hd,
    AMCD_TS_CAP_IR = 4'hf,
    AMCD_TS_SH_IR = 4'he,
    AMCD_TS_EX1_IR = 4'ha,
    AMCD_TS_PAU_IR = 4'hb,
    AMCD_TS_EX2_IR = 4'h9,
    AMCD_TS_UPD_IR = 4'h8
  } amcd_tap_st_t;

endpackage

// ===== amcd_tap.sv
`timescale 1ns/10ps
module amcd_tap #(
  parameter int unsigned IR_LEN = 6,
  parameter amcd_pkg::amcd_access_t ACCESS = amcd_pkg::AMCD_ACC_FULL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Synchronised link events
  input wire logic tck_rise,
  input wire logic tck_fall,
  input wire logic tms,
  input wire logic tdi,
  // Serial out
  output logic tdo,
  output logic tdo_oe,
  // Arbiter side
  input wire logic [31:0] capture_word,
  output logic upd_valid,
  output logic [31:0] upd_word
);
  import amcd_pkg::*;

  typedef struct packed {
    amcd_tap_st_t st;
    logic [11:0] ir;
    logic [11:0] ir_sh;
    logic [31:0] dr;
    logic byp;
    logic tdo;
    logic tdo_oe;
    logic upd;
  } amcd_tap_reg_t;

  amcd_tap_reg_t r_q;
  amcd_tap_reg_t r_d;
  logic mon_sel;

  always_comb begin
    r_d = r_q;
    r_d.upd = 1'b0;
    // Instruction decode; disabled access never selects the monitor register
    if (IR_LEN == 12) begin
      mon_sel = ((r_q.ir & AMCD_IR_MASK12) == AMCD_IR_MON12);
    end else begin
      mon_sel = ((r_q.ir & AMCD_IR_MASK6) == AMCD_IR_MON6);
    end
    mon_sel = mon_sel && (ACCESS != AMCD_ACC_DISABLED);
    if (tck_rise) begin
      case (r_q.st)
        AMCD_TS_CAP_DR: begin
          if (mon_sel) begin
            r_d.dr = capture_word;
          end
          r_d.byp = 1'b0;
        end
        AMCD_TS_SH_DR: begin
          r_d.dr = {tdi, r_q.dr[31:1]};
          r_d.byp = tdi;
        end
        AMCD_TS_CAP_IR: r_d.ir_sh = AMCD_IR_CAPTURE;
        AMCD_TS_SH_IR: begin
          r_d.ir_sh = r_q.ir_sh >> 1;
          r_d.ir_sh[IR_LEN-1] = tdi;
        end
        default: ;
      endcase
      case (r_q.st)
        AMCD_TS_RESET: r_d.st = tms ? AMCD_TS_RESET : AMCD_TS_IDLE;
        AMCD_TS_IDLE: r_d.st = tms ? AMCD_TS_SEL_DR : AMCD_TS_IDLE;
        AMCD_TS_SEL_DR: r_d.st = tms ? AMCD_TS_SEL_IR : AMCD_TS_CAP_DR;
        AMCD_TS_CAP_DR: r_d.st = tms ? AMCD_TS_EX1_DR : AMCD_TS_SH_DR;
        AMCD_TS_SH_DR: r_d.st = tms ? AMCD_TS_EX1_DR : AMCD_TS_SH_DR;
        AMCD_TS_EX1_DR: r_d.st = tms ? AMCD_TS_UPD_DR : AMCD_TS_PAU_DR;
        AMCD_TS_PAU_DR: r_d.st = tms ? AMCD_TS_EX2_DR : AMCD_TS_PAU_DR;
        AMCD_TS_EX2_DR: r_d.st = tms ? AMCD_TS_UPD_DR : AMCD_TS_SH_DR;
        AMCD_TS_UPD_DR: r_d.st = tms ? AMCD_TS_SEL_DR : AMCD_TS_IDLE;
        AMCD_TS_SEL_IR: r_d.st = tms ? AMCD_TS_RESET : AMCD_TS_CAP_IR;
        AMCD_TS_CAP_IR: r_d.st = tms ? AMCD_TS_EX1_IR : AMCD_TS_SH_IR;
        AMCD_TS_SH_IR: r_d.st = tms ? AMCD_TS_EX1_IR : AMCD_TS_SH_IR;
        AMCD_TS_EX1_IR: r_d.st = tms ? AMCD_TS_UPD_IR : AMCD_TS_PAU_IR;
        AMCD_TS_PAU_IR: r_d.st = tms ? AMCD_TS_EX2_IR : AMCD_TS_PAU_IR;
        AMCD_TS_EX2_IR: r_d.st = tms ? AMCD_TS_UPD_IR : AMCD_TS_SH_IR;
        AMCD_TS_UPD_IR: r_d.st = tms ? AMCD_TS_SEL_DR : AMCD_TS_IDLE;
        default: r_d.st = AMCD_TS_RESET;
      endcase
    end
    if (tck_fall) begin
      r_d.tdo_oe = (r_q.st == AMCD_TS_SH_DR) || (r_q.st == AMCD_TS_SH_IR);
      if (r_q.st == AMCD_TS_SH_IR) begin
        r_d.tdo = r_q.ir_sh[0];
      end else if (mon_sel) begin
        r_d.tdo = r_q.dr[0];
      end else begin
        r_d.tdo = r_q.byp;
      end
      if (r_q.st == AMCD_TS_UPD_IR) begin
        r_d.ir = r_q.ir_sh;
      end
      if (r_q.st == AMCD_TS_UPD_DR && mon_sel) begin
        r_d.upd = 1'b1;
      end
      if (r_q.st == AMCD_TS_RESET) begin
        r_d.ir = '1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_q <= '{st: AMCD_TS_RESET, ir: '1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign tdo = r_q.tdo;
  assign tdo_oe = r_q.tdo_oe;
  assign upd_valid = r_q.upd;
  assign upd_word = r_q.dr;

endmodule // amcd_tap
